// ==== logic/pdm_pkg.sv ====
// Purpose: shared constants and types for the power-down mode controller
// Assumes: one clock pclk (20 MHz), asynchronous active-low presetn
// Notes:   controller end faces APB, device end faces CPU, interrupts and PLL
// What this block does
// - power-down field at bits 15:10 selects mode
// - software writes whole field in one write
// - software writes zero to field bit 15
// - mode takes effect within nine cycles
// - software pads write with no-operations
// - 001001 enabled wake, 010001 any wake
// - cpu idle gates cpu clock, interrupts run
// - dma stays clocked during cpu idle
// - non-enabled wake resumes without service routine
// - enabled wake runs service routine then resumes
// - service routine needs global and nonmaskable enables
// - deep modes exit only by device reset
// - 011010 halts pll output clock
// - 011100 stops pll input clock
// - deep modes keep registers and ram
// - functional outputs freeze on deep entry
// - async peripheral outputs may still change
// - input stop wake waits for pll relock
// - bypassed pll makes deep modes ineffective
// - software sets pll engage before deep write
// - deep modes also gate reference and oscillator-divided clocks
// - engage selects pll or reference clock source
package pdm_pkg;

  localparam int unsigned FIELD_HI      = 15;
  localparam int unsigned FIELD_LO      = 10;
  localparam int unsigned FIELD_W       = 6;
  localparam logic [5:0]  CODE_NONE     = 6'h00;
  localparam logic [5:0]  CODE_IDLE_EN  = 6'h09;
  localparam logic [5:0]  CODE_IDLE_ANY = 6'h11;
  localparam logic [5:0]  CODE_PLL_HALT = 6'h1A;
  localparam logic [5:0]  CODE_PLL_STOP = 6'h1C;

  localparam logic [3:0]  ENTRY_CYCLES  = 4'h9;
  localparam int unsigned RELOCK_NS     = 20000;
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned RELOCK_CYCLES = (RELOCK_NS + CLK_NS - 1) / CLK_NS;

  // apb register map of the controller
  localparam logic [7:0]  ADDR_CSR      = 8'h00;
  localparam logic [7:0]  ADDR_PLLCTL   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [31:0] CSR_RESET     = 32'h0000_0000;
  localparam int unsigned GLB_EN_BIT    = 0;
  localparam int unsigned NMI_EN_BIT    = 1;
  localparam int unsigned ENGAGE_BIT    = 0;

  typedef enum logic [2:0] {
    PDM_RUN     = 3'b000,
    PDM_ENTRY   = 3'b001,
    PDM_IDLE    = 3'b010,
    PDM_HALT    = 3'b011,
    PDM_STOP    = 3'b100,
    PDM_RELOCK  = 3'b101
  } pdm_state_type;

endpackage

// ==== logic/pdm_if.sv ====
// Purpose: link between the register controller and the power-down device end
// Assumes: both ends on pclk
// Notes:   csr write is a one-cycle strobe with the full word
`timescale 1ns/1ps
interface pdm_if;
  logic        csr_wr;
  logic [31:0] csr_wdata;
  logic [31:0] csr_rdata;
  logic        pll_engage_bit;
  logic [2:0]  mode;
  logic        cpu_clk_en;
  logic        isr_run;

  modport ctl (output csr_wr, output csr_wdata, output pll_engage_bit,
               input csr_rdata, input mode, input cpu_clk_en, input isr_run);
  modport dev (input csr_wr, input csr_wdata, input pll_engage_bit,
               output csr_rdata, output mode, output cpu_clk_en, output isr_run);
endinterface

// ==== logic/pdm_device.sv ====
// Purpose: power-down mode logic, gates cpu, pll output and pll input clocks
// Assumes: irq inputs come from pins and are synchronised here
// Notes:   deep modes leave only through presetn
`timescale 1ns/1ps
module pdm_device (
  input  wire logic pclk,
  input  wire logic presetn,
  pdm_if.dev        lnk,
  input  wire logic irq_enabled,
  input  wire logic irq_any,
  input  wire logic pll_locked,
  output logic      cpu_clk_gate_en,
  output logic      dma_clk_en,
  output logic      ref_clk_gate_en,
  output logic      osc_div_clk_gate_en,
  output logic      pll_out_en,
  output logic      pll_in_en,
  output logic      sysclk_from_pll,
  output logic      io_freeze,
  output logic      isr_request
);

  typedef struct packed {
    pdm_pkg::pdm_state_type state;
    logic [31:0]            cpu_control_status;
    logic                   pll_engage;
    logic [3:0]             cnt;
    logic [14:0]            relock;
    logic [1:0]             en_sync;
    logic [1:0]             any_sync;
    logic [1:0]             lock_sync;
    logic                   cpu_en;
    logic                   ref_en;
    logic                   osc_en;
    logic                   pout_en;
    logic                   pin_en;
    logic                   from_pll;
    logic                   freeze;
    logic                   isr;
  } pdm_dev_type;

  pdm_dev_type st_reg;
  pdm_dev_type st_next;
  logic [5:0]  code;
  logic        glb_en;
  logic        nmi_en;

  assign code   = st_reg.cpu_control_status[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO];
  assign glb_en = st_reg.cpu_control_status[pdm_pkg::GLB_EN_BIT];
  assign nmi_en = st_reg.cpu_control_status[pdm_pkg::NMI_EN_BIT];

  // ==========================================================
  // next state
  always_comb begin
    st_next           = st_reg;
    st_next.en_sync   = {st_reg.en_sync[0], irq_enabled};
    st_next.any_sync  = {st_reg.any_sync[0], irq_any};
    st_next.lock_sync = {st_reg.lock_sync[0], pll_locked};
    st_next.isr       = 1'b0;
    st_next.pll_engage = lnk.pll_engage_bit;
    st_next.from_pll   = st_reg.pll_engage;
    if (lnk.csr_wr && st_reg.state == pdm_pkg::PDM_RUN) begin
      st_next.cpu_control_status = lnk.csr_wdata;
      if (lnk.csr_wdata[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO] != pdm_pkg::CODE_NONE) begin
        st_next.state = pdm_pkg::PDM_ENTRY;
        st_next.cnt   = '0;
      end
    end
    case (st_reg.state)
      pdm_pkg::PDM_ENTRY: begin
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == pdm_pkg::ENTRY_CYCLES - 4'h1) begin
          if (code == pdm_pkg::CODE_IDLE_EN || code == pdm_pkg::CODE_IDLE_ANY) begin
            st_next.state  = pdm_pkg::PDM_IDLE;
            st_next.cpu_en = 1'b0;
          end else if (code == pdm_pkg::CODE_PLL_HALT && st_reg.pll_engage) begin
            st_next.state   = pdm_pkg::PDM_HALT;
            st_next.pout_en = 1'b0;
            st_next.cpu_en  = 1'b0;
            st_next.ref_en  = 1'b0;
            st_next.osc_en  = 1'b0;
            st_next.freeze  = 1'b1;
          end else if (code == pdm_pkg::CODE_PLL_STOP && st_reg.pll_engage) begin
            st_next.state   = pdm_pkg::PDM_STOP;
            st_next.pin_en  = 1'b0;
            st_next.pout_en = 1'b0;
            st_next.cpu_en  = 1'b0;
            st_next.ref_en  = 1'b0;
            st_next.osc_en  = 1'b0;
            st_next.freeze  = 1'b1;
          end else begin
            st_next.state = pdm_pkg::PDM_RUN;
            st_next.cpu_control_status[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO] = pdm_pkg::CODE_NONE;
          end
        end
      end
      pdm_pkg::PDM_IDLE: begin
        if (st_reg.en_sync[1] ||
            (code == pdm_pkg::CODE_IDLE_ANY && st_reg.any_sync[1])) begin
          st_next.state  = pdm_pkg::PDM_RUN;
          st_next.cpu_en = 1'b1;
          st_next.cpu_control_status[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO] = pdm_pkg::CODE_NONE;
          st_next.isr    = st_reg.en_sync[1] && glb_en && nmi_en;
        end
      end
      pdm_pkg::PDM_HALT: st_next.state = pdm_pkg::PDM_HALT;
      pdm_pkg::PDM_STOP: st_next.state = pdm_pkg::PDM_STOP;
      pdm_pkg::PDM_RELOCK: begin
        st_next.relock = st_reg.relock + 15'h0001;
        if (st_reg.lock_sync[1] &&
            st_reg.relock >= 15'(pdm_pkg::RELOCK_CYCLES)) begin
          st_next.state  = pdm_pkg::PDM_RUN;
          st_next.cpu_en = 1'b1;
          st_next.ref_en = 1'b1;
          st_next.osc_en = 1'b1;
        end
      end
      default: ;
    endcase
  end

  // ==========================================================
  // registers; reset wakes deep modes, cold start relocks pll
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.state    <= pdm_pkg::PDM_RELOCK;
      st_reg.cpu_control_status      <= pdm_pkg::CSR_RESET;
      st_reg.pout_en  <= 1'b1;
      st_reg.pin_en   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_clk_gate_en     = st_reg.cpu_en;
  assign dma_clk_en          = st_reg.pout_en;
  assign ref_clk_gate_en     = st_reg.ref_en;
  assign osc_div_clk_gate_en = st_reg.osc_en;
  assign pll_out_en          = st_reg.pout_en;
  assign pll_in_en           = st_reg.pin_en;
  assign sysclk_from_pll     = st_reg.from_pll;
  assign io_freeze           = st_reg.freeze;
  assign isr_request         = st_reg.isr;
  assign lnk.csr_rdata       = st_reg.cpu_control_status;
  assign lnk.mode            = st_reg.state;
  assign lnk.cpu_clk_en      = st_reg.cpu_en;
  assign lnk.isr_run         = st_reg.isr;

endmodule // pdm_device

// ==== logic/pdm_ctl.sv ====
// Purpose: apb slave holding pll engage, giving software access to cpu control/status held in the device end
// Assumes: zero-wait apb, 32-bit aligned words
// Notes:   csr writes are forwarded whole to the device end
`timescale 1ns/1ps
module pdm_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  pdm_if.ctl               lnk
);

  typedef struct packed {
    logic        wr;
    logic [31:0] wdata;
    logic        pll_engage;
    logic [31:0] rdata;
    logic        err;
  } pdm_ctl_type;

  pdm_ctl_type st_reg;
  pdm_ctl_type st_next;
  logic        acc;

  assign acc = psel && penable;

  // ==========================================================
  // apb decode
  always_comb begin
    st_next       = st_reg;
    st_next.wr    = 1'b0;
    st_next.err   = 1'b0;
    st_next.rdata = '0;
    if (psel && !penable) begin
      if (paddr == pdm_pkg::ADDR_CSR) begin
        st_next.rdata = lnk.csr_rdata;
      end else if (paddr == pdm_pkg::ADDR_PLLCTL) begin
        st_next.rdata = {31'h0000_0000, st_reg.pll_engage};
      end else if (paddr == pdm_pkg::ADDR_STATUS) begin
        st_next.rdata = {27'h000_0000, lnk.isr_run, lnk.cpu_clk_en, lnk.mode};
      end else begin
        st_next.err = 1'b1;
      end
    end
    if (acc && pwrite) begin
      st_next.err = st_reg.err;
      if (paddr == pdm_pkg::ADDR_CSR) begin
        st_next.wr    = 1'b1;
        st_next.wdata = pwdata;
      end else if (paddr == pdm_pkg::ADDR_PLLCTL) begin
        st_next.pll_engage = pwdata[pdm_pkg::ENGAGE_BIT];
      end
    end else if (acc) begin
      st_next.rdata = st_reg.rdata;
      st_next.err   = st_reg.err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata             = st_reg.rdata;
  assign pready             = 1'b1;
  assign pslverr            = st_reg.err;
  assign lnk.csr_wr         = st_reg.wr;
  assign lnk.csr_wdata      = st_reg.wdata;
  assign lnk.pll_engage_bit = st_reg.pll_engage;

endmodule // pdm_ctl

// ==== test/pdm_assertions.sv ====
// Purpose: checks on the link between controller and device end
// Assumes: one pclk domain, presetn async active low
// Notes:   watches pdm_if signals as plain inputs
`timescale 1ns/1ps
module pdm_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        csr_wr,
  input wire logic [31:0] csr_wdata,
  input wire logic [31:0] csr_rdata,
  input wire logic        pll_engage_bit,
  input wire logic [2:0]  mode,
  input wire logic        cpu_clk_en,
  input wire logic        isr_run
);
  // ==========================================
  // helpers
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [5:0] f;
  logic [5:0] rd_f;
  logic       go;
  logic       deep;
  logic       idle_code;
  logic       known;
  logic       in_run;
  logic       in_idle;
  logic       in_deep;
  logic       irq_ok;
  assign f         = csr_wdata[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO];
  assign rd_f      = csr_rdata[pdm_pkg::FIELD_HI:pdm_pkg::FIELD_LO];
  assign in_run    = mode == pdm_pkg::PDM_RUN;
  assign in_idle   = mode == pdm_pkg::PDM_IDLE;
  assign in_deep   = mode == pdm_pkg::PDM_HALT || mode == pdm_pkg::PDM_STOP;
  assign go        = csr_wr && in_run;
  assign deep      = f == pdm_pkg::CODE_PLL_HALT || f == pdm_pkg::CODE_PLL_STOP;
  assign idle_code = f == pdm_pkg::CODE_IDLE_EN || f == pdm_pkg::CODE_IDLE_ANY;
  assign known     = f == pdm_pkg::CODE_NONE || idle_code || deep;
  assign irq_ok    = csr_rdata[pdm_pkg::GLB_EN_BIT] && csr_rdata[pdm_pkg::NMI_EN_BIT];
  // ==========================================
  // properties
  idle_entry_a: assert property (go && idle_code |-> ##[1:11] in_idle)
    else $error("idle mode not entered");
  halt_entry_a: assert property (go && f == pdm_pkg::CODE_PLL_HALT && pll_engage_bit
    |-> ##[1:11] mode == pdm_pkg::PDM_HALT)
    else $error("halt mode not entered");
  stop_entry_a: assert property (go && f == pdm_pkg::CODE_PLL_STOP && pll_engage_bit
    |-> ##[1:11] mode == pdm_pkg::PDM_STOP)
    else $error("stop mode not entered");
  bypass_run_a: assert property (go && deep && !pll_engage_bit |-> ##12 in_run)
    else $error("bypassed deep code stopped device");
  reserved_run_a: assert property (go && !known |-> ##12 in_run && rd_f == pdm_pkg::CODE_NONE)
    else $error("reserved code not treated as run");
  deep_hold_a: assert property (in_deep |=> mode == $past(mode))
    else $error("deep mode left without reset");
  deep_keep_a: assert property (in_deep && csr_wr |=> $stable(csr_rdata))
    else $error("register changed in deep mode");
  idle_gate_a: assert property (in_idle && $past(in_idle) |-> !cpu_clk_en)
    else $error("cpu clocked in idle");
  wake_clear_a: assert property (in_idle ##1 in_run |-> rd_f == pdm_pkg::CODE_NONE && cpu_clk_en)
    else $error("field not cleared on wake");
  isr_enable_a: assert property ($rose(isr_run) |-> irq_ok)
    else $error("service run without enables");
  isr_pulse_a: assert property (isr_run |=> !isr_run)
    else $error("service request longer than one cycle");
endmodule // pdm_assertions

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for both ends of the power-down controller
// Assumes: 20 MHz pclk, apb master tasks
// Notes:   idle, deep, bypass and reserved codes
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        irq_en, irq_any, locked, cg, dma, refg, oscg, pout, pin, sysp, frz, isr;
  logic [5:0]  c;
  int          n_errors, total_checks, n_isr, n0, k;
  pdm_if lnk ();
  pdm_ctl u_pdm_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  pdm_device u_pdm_device (.pclk(pclk), .presetn(presetn), .lnk(lnk), .irq_enabled(irq_en),
    .irq_any(irq_any), .pll_locked(locked), .cpu_clk_gate_en(cg), .dma_clk_en(dma),
    .ref_clk_gate_en(refg), .osc_div_clk_gate_en(oscg), .pll_out_en(pout), .pll_in_en(pin),
    .sysclk_from_pll(sysp), .io_freeze(frz), .isr_request(isr));
  pdm_assertions u_pdm_assertions (.pclk(pclk), .presetn(presetn), .csr_wr(lnk.csr_wr),
    .csr_wdata(lnk.csr_wdata), .csr_rdata(lnk.csr_rdata), .pll_engage_bit(lnk.pll_engage_bit),
    .mode(lnk.mode), .cpu_clk_en(lnk.cpu_clk_en), .isr_run(lnk.isr_run));
  // ==========================================
  // clock, monitor, tasks
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) if (isr === 1'b1) n_isr <= n_isr + 1;
  task chk(input string s, input logic [31:0] x, input logic [31:0] y);
    total_checks++;
    if (x !== y) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, x, y);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic r;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      r = pready;
      q = prdata;
      e = pslverr;
    end while (r !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wmode(input logic [2:0] m);
    int i;
    i = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      i++;
    end while (q[2:0] !== m && i < 300);
    chk("mode", 32'(m), 32'(q[2:0]));
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    complete_run;
  end
  // ==========================================
  // tests
  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0000_0000;
    irq_en       = 1'b0;
    irq_any      = 1'b0;
    locked       = 1'b1;
    n_errors     = 0;
    total_checks = 0;
    n_isr        = 0;
    rst;
    wmode(3'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("csr reset", pdm_pkg::CSR_RESET, q);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped slverr", 32'h1, 32'(e));
    apb(1'b1, 8'h04, 32'h1);
    repeat (4) @(posedge pclk);
    chk("sysclk pll", 32'h1, 32'(sysp));
    $display("test regs done");
    for (k = 0; k < 3; k++) begin
      c = (k == 1) ? 6'h11 : 6'h09;
      n0 = n_isr;
      apb(1'b1, 8'h00, {16'h0, c, 8'h0, (k == 2) ? 2'b01 : 2'b11});
      wmode(3'h2);
      chk("cpu gate idle", 32'h0, 32'(cg));
      chk("dma idle", 32'h1, 32'(dma));
      if (k != 1) begin
        irq_any <= 1'b1;
        repeat (8) @(posedge pclk);
        wmode(3'h2);
        irq_en <= 1'b1;
      end else irq_any <= 1'b1;
      wmode(3'h0);
      chk("isr count", (k == 0) ? 32'h1 : 32'h0, 32'(n_isr - n0));
      apb(1'b0, 8'h00, 32'h0);
      chk("field clear", 32'h0, 32'(q[15:10]));
      irq_en  <= 1'b0;
      irq_any <= 1'b0;
    end
    $display("test idle done");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, {16'h0, 6'h1A, 10'h0});
    repeat (14) @(posedge pclk);
    wmode(3'h0);
    chk("bypass sysclk", 32'h0, 32'(sysp));
    apb(1'b1, 8'h00, {16'h0, 6'h05, 10'h0});
    repeat (14) @(posedge pclk);
    wmode(3'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("reserved field", 32'h0, 32'(q[15:10]));
    $display("test bypass done");
    for (k = 0; k < 2; k++) begin
      c = k ? 6'h1C : 6'h1A;
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h00, {16'h0, c, 10'h0});
      wmode(k ? 3'h4 : 3'h3);
      chk("cpu gate deep", 32'h0, 32'(cg));
      chk("ref osc gates", 32'h0, 32'({refg, oscg}));
      chk("freeze", 32'h1, 32'(frz));
      chk("pll gate", 32'h0, 32'(k ? pin : pout));
      irq_en  <= 1'b1;
      irq_any <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b1, 8'h00, 32'h0);
      wmode(k ? 3'h4 : 3'h3);
      apb(1'b0, 8'h00, 32'h0);
      chk("csr kept", {16'h0, c, 10'h0}, q);
      irq_en  <= 1'b0;
      irq_any <= 1'b0;
      locked  <= (k == 0);
      rst;
      repeat (100) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      chk("relock wait", 32'h5, 32'(q[2:0]));
      if (k == 1) begin
        repeat (400) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        chk("relock lock wait", 32'h5, 32'(q[2:0]));
        locked <= 1'b1;
      end
      wmode(3'h0);
      chk("clocks back", 32'h7, 32'({cg, refg, oscg}));
    end
    $display("test deep done");
    complete_run;
  end
endmodule // tb_top
